// ==== bwd_map.svh ====
// Purpose: Constants of the card control logic (watchdog, wait states, decode)
// Assumes: 40 MHz aclk; register offsets are byte addresses on AXI4-Lite
// Notes: Definitions only
`ifndef BWD_MAP_SVH
`define BWD_MAP_SVH
`define BWD_CLK_HZ 40000000
`define BWD_OFS_CONFIG 8'h00
`define BWD_OFS_STATUS 8'h04
`define BWD_OFS_TRIM 8'h08
`define BWD_WAIT_3 4'h3
`define BWD_WAIT_5 4'h5
`define BWD_WAIT_8 4'h8
`define BWD_PULSE_MS 8
`define BWD_PULSE_CYC ((`BWD_CLK_HZ / 1000) * `BWD_PULSE_MS)
`define BWD_TICK_US 100
`define BWD_TICK_CYC ((`BWD_CLK_HZ / 1000000) * `BWD_TICK_US)
`define BWD_TRIM_SHORT 16'h0190
`define BWD_TRIM_MED 16'h0064
`define BWD_TRIM_LONG 16'h000A
`define BWD_TRIM_RESET 16'h0271
// Medium range, trim 625: 625 * 16 ticks of 100 us, about one second out of reset
`define BWD_CFG_RESET 32'h0000_080A
`define BWD_CFG_WAIT_EN 0
`define BWD_CFG_FETCH_Q 1
`define BWD_CFG_EXT 2
`define BWD_CFG_ASTABLE 3
`define BWD_CFG_ROUTE 4
`define BWD_CFG_WCNT_LO 5
`define BWD_CFG_SIZE_LO 8
`define BWD_CFG_RANGE_LO 11
`define BWD_CFG_SW_LO 16
`endif

// ==== bwd_pkg.sv ====
// Purpose: Types of the card control logic
// Assumes: Constants live in bwd_map.svh
// Notes: Range codes are 0 short, 1 medium, 2 long
package bwd_pkg;
  typedef struct packed {
    logic [19:0] addr;
    logic iorq_n;
    logic rd_n;
    logic wr_n;
    logic opcode_fetch_n;
  } bwd_bus_type;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_HOLD = 3'b100
  } bwd_wait_state_type;
endpackage

// ==== bwd_watchdog.sv ====
// Purpose: Watchdog, wait-state generator and base decode of an I/O expansion card
// Assumes: Backplane signals synchronous to aclk; card clock is the backplane clock
// Notes: Jumper options live in a config register reached over AXI4-Lite
// Functional notes
// - Selected I/O accesses are stretched by 3, 5 or 8 wait states, default 3.
// - Wait line driven only when wait output enable is set; default off.
// - Wait states only for I/O cycles that select this card.
// - Wait count is timed in backplane clock cycles, supplied by the control card.
// - Opcode-fetch qualification option, default on, makes decode honour fetch signal.
// - Decoder has normal 256-byte mode (default) and extended 64 to 1024 Kbyte mode.
// - Extended size select adds A16, then A17, A18, A19 to the compare.
// - Monostable: after timeout output stays asserted until reset.
// - Astable: after timeout output asserts about 8 msec then releases.
// - Mode select: clear is monostable, set is astable, astable default.
// - Three timeout ranges short, medium, long; trim sets exact time inside.
// - Production default timeout is about one second.
// - Reset-request line driven only when routing option is set.
// - Alarm LED lit whenever watchdog output is asserted.
// - Timeout counted from backplane clock supplied by control card.
// - Card selected for 16 consecutive I/O addresses from base.
// - Any read of the card block retriggers watchdog; read data meaningless.
// - Base switches inverted: closed is zero, open is one.
// - Normal mode compares low switch bank with A4 to A7 only.
`include "bwd_map.svh"
module bwd_watchdog #(
  parameter int unsigned TICK_CYC = `BWD_TICK_CYC,
  parameter int unsigned PULSE_CYC = `BWD_PULSE_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Backplane I/O bus
  input wire bwd_pkg::bwd_bus_type bus,
  output logic card_select,
  output logic wait_n_out,
  output logic wait_n_oe,
  output logic reset_req_n_out,
  output logic reset_req_n_oe,
  output logic alarm_led
);
  import bwd_pkg::*;

  // Register state of the block, apart from the registered outputs
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] bresp;
    logic [31:0] cfg;
    logic [15:0] trim;
    bwd_wait_state_type wst;
    logic [3:0] wcnt;
    logic prev_cycle;
    logic [15:0] tick_cnt;
    logic [31:0] wd_cnt;
    logic wd_out;
    logic [31:0] pulse_cnt;
    logic sel;
    logic retrig_seen;
  } bwd_state_type;

  bwd_state_type st;
  bwd_state_type next_st;

  // Wait count decode, used by the wait counter on entry to ST_WAIT
  function automatic logic [3:0] wait_count(input logic [2:0] code);
    begin
      unique case (code)
        3'd1: wait_count = `BWD_WAIT_5;
        3'd2: wait_count = `BWD_WAIT_8;
        default: wait_count = `BWD_WAIT_3;
      endcase
    end
  endfunction

  // Timeout in ticks: trim scaled by the range multiplier
  function automatic logic [31:0] timeout_ticks(input logic [1:0] rng, input logic [15:0] trm);
    begin
      unique case (rng)
        2'd0: timeout_ticks = {16'h0000, trm};
        2'd1: timeout_ticks = {12'h000, trm, 4'h0};
        default: timeout_ticks = {8'h00, trm, 8'h00};
      endcase
      if (timeout_ticks == 32'h0000_0000)
      begin
        timeout_ticks = 32'h0000_0001;
      end
    end
  endfunction

  logic [31:0] cfg_word;
  logic [7:0] sw_low;
  logic [7:0] sw_high;
  logic [3:0] sw_ext;
  logic [3:0] ext_mask;
  logic match;
  logic io_cycle;
  logic tick;
  logic retrig;

  // Switch banks are inverted: a closed switch compares as zero
  assign cfg_word = st.cfg;
  assign sw_low = ~cfg_word[`BWD_CFG_SW_LO +: 8];
  assign sw_high = ~cfg_word[`BWD_CFG_SW_LO + 8 +: 8];
  assign sw_ext = sw_low[3:0];

  // Extended space size adds A16 upward, one bit per step
  always_comb
  begin
    unique case (cfg_word[`BWD_CFG_SIZE_LO +: 3])
      3'd1: ext_mask = 4'b0001;
      3'd2: ext_mask = 4'b0011;
      3'd3: ext_mask = 4'b0111;
      3'd4: ext_mask = 4'b1111;
      default: ext_mask = 4'b0000;
    endcase
  end

  // Base decode: A4..A7 always, A8..A15 and masked A16..A19 in extended mode
  always_comb
  begin
    match = (bus.addr[7:4] == sw_low[7:4]);
    if (cfg_word[`BWD_CFG_EXT])
    begin
      match = match && (bus.addr[15:8] == sw_high)
        && (((bus.addr[19:16] ^ sw_ext) & ext_mask) == 4'h0);
    end
    if (cfg_word[`BWD_CFG_FETCH_Q])
    begin
      match = match && bus.opcode_fetch_n;
    end
  end

  assign io_cycle = !bus.iorq_n && (!bus.rd_n || !bus.wr_n) && match;
  assign tick = (st.tick_cnt == 16'(TICK_CYC - 1));
  assign retrig = io_cycle && !bus.rd_n && !st.retrig_seen;

  // Next-state logic for bus slave, wait generator and watchdog
  always_comb
  begin
    next_st = st;
    next_st.sel = io_cycle;
    next_st.prev_cycle = io_cycle;
    next_st.retrig_seen = io_cycle && !bus.rd_n;
    // Write channel: address and data accepted in either order
    if (s_axi_awvalid && !st.aw_got && !st.bvalid)
    begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_got && !st.bvalid)
    begin
      next_st.w_got = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (st.aw_got && st.w_got)
    begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = 2'b00;
      if (st.aw_addr == `BWD_OFS_CONFIG)
      begin
        for (int i = 0; i < 4; i++)
        begin
          if (st.w_strb[i])
          begin
            next_st.cfg[i*8 +: 8] = st.w_data[i*8 +: 8];
          end
        end
      end
      else if (st.aw_addr == `BWD_OFS_TRIM)
      begin
        for (int i = 0; i < 2; i++)
        begin
          if (st.w_strb[i])
          begin
            next_st.trim[i*8 +: 8] = st.w_data[i*8 +: 8];
          end
        end
      end
      else if (st.aw_addr != `BWD_OFS_STATUS)
      begin
        next_st.bresp = 2'b10;
      end
    end
    if (st.bvalid && s_axi_bready)
    begin
      next_st.bvalid = 1'b0;
    end
    // Read channel: one-cycle accept, data valid in the same cycle as arready
    next_st.arready = 1'b0;
    if (s_axi_arvalid && !st.arready && !st.rvalid)
    begin
      next_st.arready = 1'b1;
      next_st.rvalid = 1'b1;
      next_st.rresp = 2'b00;
      unique case (s_axi_araddr)
        `BWD_OFS_CONFIG: next_st.rdata = st.cfg;
        `BWD_OFS_STATUS: next_st.rdata = {26'h0, st.wst == ST_WAIT, st.sel, 3'h0, st.wd_out};
        `BWD_OFS_TRIM: next_st.rdata = {16'h0000, st.trim};
        default:
        begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = 2'b10;
        end
      endcase
    end
    if (st.rvalid && s_axi_rready)
    begin
      next_st.rvalid = 1'b0;
    end
    // Wait generator, counted in backplane clocks
    unique case (st.wst)
      ST_IDLE:
      begin
        if (io_cycle && !st.prev_cycle)
        begin
          next_st.wst = ST_WAIT;
          next_st.wcnt = wait_count(cfg_word[`BWD_CFG_WCNT_LO +: 3]);
        end
      end
      ST_WAIT:
      begin
        next_st.wcnt = st.wcnt - 4'h1;
        if (st.wcnt == 4'h1)
        begin
          next_st.wst = ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        // Stay until the access ends so one access gets one stretch
        if (!io_cycle)
        begin
          next_st.wst = ST_IDLE;
        end
      end
      default: next_st.wst = ST_IDLE;
    endcase
    // Timebase and watchdog timeout
    next_st.tick_cnt = tick ? 16'h0000 : st.tick_cnt + 16'h0001;
    if (retrig)
    begin
      next_st.wd_cnt = 32'h0000_0000;
    end
    else if (tick && !st.wd_out)
    begin
      next_st.wd_cnt = st.wd_cnt + 32'h0000_0001;
      if (st.wd_cnt + 32'h0000_0001 >= timeout_ticks(cfg_word[`BWD_CFG_RANGE_LO +: 2], st.trim))
      begin
        next_st.wd_out = 1'b1;
        next_st.pulse_cnt = 32'h0000_0000;
        next_st.wd_cnt = 32'h0000_0000;
      end
    end
    // Astable pulse ends by itself; monostable holds until reset
    if (st.wd_out && cfg_word[`BWD_CFG_ASTABLE])
    begin
      next_st.pulse_cnt = st.pulse_cnt + 32'h0000_0001;
      if (st.pulse_cnt == 32'(PULSE_CYC - 1))
      begin
        next_st.wd_out = 1'b0;
        next_st.wd_cnt = 32'h0000_0000;
      end
    end
  end

  // State register; reset clears watchdog, wait counter and timeout
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= '0;
      st.cfg <= `BWD_CFG_RESET;
      st.trim <= `BWD_TRIM_RESET;
      st.wst <= ST_IDLE;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Registered outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wait_n_out <= 1'b1;
      wait_n_oe <= 1'b0;
      reset_req_n_out <= 1'b1;
      reset_req_n_oe <= 1'b0;
      alarm_led <= 1'b0;
      card_select <= 1'b0;
    end
    else
    begin
      wait_n_out <= !(next_st.wst == ST_WAIT);
      wait_n_oe <= cfg_word[`BWD_CFG_WAIT_EN] && (next_st.wst == ST_WAIT);
      reset_req_n_out <= !next_st.wd_out;
      reset_req_n_oe <= cfg_word[`BWD_CFG_ROUTE] && next_st.wd_out;
      alarm_led <= next_st.wd_out;
      card_select <= io_cycle;
    end
  end

  assign s_axi_awready = !st.aw_got && !st.bvalid;
  assign s_axi_wready = !st.w_got && !st.bvalid;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;

  sequence s_wait_start;
    $rose(st.wst == ST_WAIT);
  endsequence

  a_led_follows_wd: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 alarm_led == $past(next_st.wd_out)) else $error("Alarm LED not following watchdog");
  a_wait_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    !cfg_word[`BWD_CFG_WAIT_EN] |-> !wait_n_oe) else $error("Wait driven while disabled");
  a_route_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    !cfg_word[`BWD_CFG_ROUTE] |-> !reset_req_n_oe) else $error("Reset request driven");
  a_wait_three: assert property (@(posedge aclk) disable iff (!aresetn)
    s_wait_start and (cfg_word[`BWD_CFG_WCNT_LO +: 3] == 3'd0) |->
    (st.wst == ST_WAIT) [*3] ##1 (st.wst == ST_HOLD)) else $error("Wait length not 3");
  a_wait_five: assert property (@(posedge aclk) disable iff (!aresetn)
    s_wait_start and (cfg_word[`BWD_CFG_WCNT_LO +: 3] == 3'd1) |->
    (st.wst == ST_WAIT) [*5] ##1 (st.wst == ST_HOLD)) else $error("Wait length not 5");
  a_wait_only_sel: assert property (@(posedge aclk) disable iff (!aresetn)
    s_wait_start |-> $past(io_cycle)) else $error("Wait without card select");
  a_mono_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    st.wd_out && !cfg_word[`BWD_CFG_ASTABLE] && $stable(cfg_word) |=> st.wd_out)
    else $error("Monostable output released");
  a_fetch_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_word[`BWD_CFG_FETCH_Q] && !bus.opcode_fetch_n |-> !io_cycle)
    else $error("Selected during opcode fetch");
  a_retrig_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    retrig |=> st.wd_cnt == 32'h0000_0000) else $error("Retrigger ignored");
  a_normal_ignores: assert property (@(posedge aclk) disable iff (!aresetn)
    !cfg_word[`BWD_CFG_EXT] && (bus.addr[7:4] != sw_low[7:4]) |-> !match)
    else $error("Normal decode mismatch");
endmodule // bwd_watchdog

// ==== bwd_card_model.sv ====
// Purpose: Backplane control card model driving the card's I/O bus
// Assumes: Wait and reset request lines float to a pull-up when released
// Notes: Resets the whole system for a few cycles on a reset request
module bwd_card_model (
  // Clock
  input wire logic aclk,
  // Card lines
  output bwd_pkg::bwd_bus_type bus,
  input wire logic card_select,
  input wire logic wait_n_out,
  input wire logic wait_n_oe,
  input wire logic reset_req_n_out,
  input wire logic reset_req_n_oe,
  // System reset
  output logic sys_rst_n
);
  timeunit 1ns;
  timeprecision 100ps;
  import bwd_pkg::*;
  logic wait_l;
  logic req_l;
  int hold = 0;
  // Released lines read as the pull-up level
  assign wait_l = wait_n_oe ? wait_n_out : 1'b1;
  assign req_l = reset_req_n_oe ? reset_req_n_out : 1'b1;
  initial bus = '{20'h0_0000, 1'b1, 1'b1, 1'b1, 1'b1};
  // A request pulls system reset low for four cycles
  always @(posedge aclk)
  begin
    if (!req_l && hold == 0)
      hold <= 4;
    else if (hold > 0)
      hold <= hold - 1;
    sys_rst_n <= (hold == 0);
  end
  // One read cycle, strobes held while the card stretches it
  task automatic io_cycle(input logic [19:0] a, input logic io, input logic f,
    output int waits, output logic sel);
    waits = 0;
    sel = 1'b0;
    @(posedge aclk);
    bus <= '{a, !io, 1'b0, 1'b1, !f};
    for (int i = 0; i < 20; i++)
    begin
      @(posedge aclk);
      sel |= card_select;
      if (!wait_l)
        waits++;
      else if (i > 1)
        break;
    end
    // Idle address changes so a stale decode cannot look right
    bus <= '{~a, 1'b1, 1'b1, 1'b1, 1'b1};
  endtask
endmodule // bwd_card_model

// ==== test_bus_watchdog_wait_decode.sv ====
// Purpose: Self-checking bench of the card's watchdog, wait and decode logic
// Assumes: Short tick and pulse counts (4 and 20 cycles)
// Notes: Registers reached through AXI4-Lite tasks
module test_bus_watchdog_wait_decode;
  timeunit 1ns;
  timeprecision 100ps;
  import bwd_pkg::*;
  logic aclk, rst_n, aresetn, sys_rst_n;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  bwd_bus_type bus;
  logic card_select, wait_n_out, wait_n_oe, rq_out, rq_oe, alarm_led, req_seen;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  // Control card supplies the clock that all counts run on
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  assign aresetn = rst_n & sys_rst_n;
  bwd_watchdog #(.TICK_CYC(4), .PULSE_CYC(20)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .bus(bus), .card_select(card_select), .wait_n_out(wait_n_out), .wait_n_oe(wait_n_oe),
    .reset_req_n_out(rq_out), .reset_req_n_oe(rq_oe), .alarm_led(alarm_led));
  bwd_card_model model (.aclk(aclk), .bus(bus), .card_select(card_select),
    .wait_n_out(wait_n_out), .wait_n_oe(wait_n_oe), .reset_req_n_out(rq_out),
    .reset_req_n_oe(rq_oe), .sys_rst_n(sys_rst_n));
  // Sticky flag: request seen driven low together with the alarm
  always @(posedge aclk)
  begin
    cycles++;
    if (rq_oe === 1'b1 && rq_out === 1'b0 && alarm_led === 1'b1)
      req_seen <= 1'b1;
    if (cycles == 20000)
    begin
      mismatches++;
      results();
    end
  end
  task check_val(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic cfg(input logic [31:0] v);
    logic [1:0] r;
    axi_write(8'h00, v, r);
  endtask
  // One backplane read, judged on wait count and selection
  task automatic io(input logic [19:0] a, input logic is_io, input logic f, input int ew,
    input logic es);
    int w;
    logic s;
    model.io_cycle(a, is_io, f, w, s);
    check_val("wait cycles", ew, w);
    check_val("card select", {31'h0, es}, {31'h0, s});
  endtask
  task automatic wait_alarm(input logic lvl, output int n);
    n = 0;
    while (alarm_led !== lvl && n < 80)
    begin
      @(posedge aclk);
      n++;
    end
  endtask
  task t_reset;
    logic [31:0] d;
    logic [1:0] r;
    axi_read(8'h00, d, r);
    check_val("config", 32'h0000_080A, d);
    axi_read(8'h08, d, r);
    check_val("trim", 32'h0000_0271, d);
    axi_read(8'h0C, d, r);
    check_val("unmapped resp", 32'h0000_0002, {30'h0, r});
    axi_write(8'h0C, 32'h0000_0000, r);
    check_val("unmapped write resp", 32'h0000_0002, {30'h0, r});
  endtask
  task t_decode;
    int n[3] = '{3, 5, 8};
    // Base 0x50 from inverted low bank; high bank ignored in normal mode
    for (int k = 0; k < 3; k++)
    begin
      cfg(32'h12AF_000B | (32'(k) << 5));
      io(20'hA_BC5F, 1'b1, 1'b0, n[k], 1'b1);
    end
    io(20'h0_0060, 1'b1, 1'b0, 0, 1'b0);
    io(20'h0_0050, 1'b0, 1'b0, 0, 1'b0);
    cfg(32'h12AF_000A);
    io(20'h0_0050, 1'b1, 1'b0, 0, 1'b1);
    io(20'h0_0050, 1'b1, 1'b1, 0, 1'b0);
    cfg(32'h12AF_0008);
    io(20'h0_0050, 1'b1, 1'b1, 0, 1'b1);
    cfg(32'hEDAF_000C);
    io(20'h3_1250, 1'b1, 1'b0, 0, 1'b1);
    io(20'h0_1350, 1'b1, 1'b0, 0, 1'b0);
    cfg(32'hEDAF_010C);
    io(20'h3_1250, 1'b1, 1'b0, 0, 1'b0);
    io(20'h2_1250, 1'b1, 1'b0, 0, 1'b1);
    cfg(32'hEDAF_040C);
    io(20'h8_1250, 1'b1, 1'b0, 0, 1'b0);
  endtask
  task t_dog;
    int n;
    logic [1:0] r;
    logic [31:0] d;
    // Astable, unrouted, base 0xF0; trim of 5 ticks is 20 cycles
    cfg(32'h0000_000A);
    io(20'h0_00F3, 1'b1, 1'b0, 0, 1'b1);
    axi_write(8'h08, 32'h0000_0005, r);
    check_val("trim write resp", 32'h0000_0000, {30'h0, r});
    repeat (8)
    begin
      io(20'h0_00FC, 1'b1, 1'b0, 0, 1'b1);
      repeat (5) @(posedge aclk);
    end
    check_val("alarm retriggered", 32'h0, {31'h0, alarm_led});
    wait_alarm(1'b1, n);
    check_val("alarm astable", 32'h1, {31'h0, alarm_led});
    check_val("request unrouted", 32'h0, {31'h0, rq_oe});
    wait_alarm(1'b0, n);
    check_val("pulse length", 32'h1, {31'h0, n >= 18 && n <= 22});
    cfg(32'h0000_0002);
    wait_alarm(1'b1, n);
    repeat (60) @(posedge aclk);
    check_val("alarm held", 32'h1, {31'h0, alarm_led});
    check_val("request held off", 32'h0, {31'h0, rq_oe});
    cfg(32'h0000_0012);
    repeat (12) @(posedge aclk);
    check_val("request seen", 32'h1, {31'h0, req_seen});
    check_val("alarm cleared", 32'h0, {31'h0, alarm_led});
    axi_read(8'h00, d, r);
    check_val("config after reset", 32'h0000_080A, d);
  endtask
  initial
  begin
    rst_n = 1'b0;
    req_seen = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    repeat (10) @(posedge aclk);
    rst_n <= 1'b1;
    t_reset();
    t_decode();
    t_dog();
    results();
  end
endmodule // test_bus_watchdog_wait_decode
